// >>> rtl/srlt_consts.svh
// constants for the status reporting and level trigger block
`ifndef SRLT_CONSTS_SVH
`define SRLT_CONSTS_SVH
`define SRLT_ADDR_VOLT_IMM 5'h00
`define SRLT_ADDR_VOLT_TRIG 5'h01
`define SRLT_ADDR_VMAX_IMM 5'h02
`define SRLT_ADDR_VMIN_IMM 5'h03
`define SRLT_ADDR_VMAX_TRIG 5'h04
`define SRLT_ADDR_VMIN_TRIG 5'h05
`define SRLT_ADDR_OVTHR 5'h06
`define SRLT_ADDR_AB_COND 5'h07
`define SRLT_ADDR_AB_RISE 5'h08
`define SRLT_ADDR_AB_FALL 5'h09
`define SRLT_ADDR_AB_EVENT 5'h0A
`define SRLT_ADDR_AB_ENAB 5'h0B
`define SRLT_ADDR_OP_COND 5'h0C
`define SRLT_ADDR_OP_RISE 5'h0D
`define SRLT_ADDR_OP_FALL 5'h0E
`define SRLT_ADDR_OP_EVENT 5'h0F
`define SRLT_ADDR_OP_ENAB 5'h10
`define SRLT_ADDR_STB 5'h11
`define SRLT_ADDR_INIT 5'h12
`define SRLT_VMAX_IMM 16'hFFFF
`define SRLT_VMIN_IMM 16'h0000
`define SRLT_VMAX_TRIG 16'hFFFF
`define SRLT_VMIN_TRIG 16'h0000
`define SRLT_BIT_OVTRIP 0
`define SRLT_BIT_OCTRIP 1
`define SRLT_BIT_OVTEMP 4
`define SRLT_BIT_INHIBIT 9
`define SRLT_BIT_UNREG 10
`define SRLT_BIT_WAIT 5
`define SRLT_BIT_CVOLT 8
`define SRLT_BIT_CCURR 10
`define SRLT_STB_ABN 3
`define SRLT_STB_MSGAV 4
`define SRLT_STB_EVSUM 5
`define SRLT_STB_MASTER 6
`define SRLT_STB_OPS 7
`endif

// >>> rtl/srlt_pkg.sv
// types for the status reporting and level trigger block
package srlt_pkg;
    typedef logic [15:0] srlt_word_t;
    typedef enum logic [1:0] {
        SRLT_IDLE = 2'b01,
        SRLT_ARMED = 2'b10
    } srlt_trig_e;
    typedef struct packed {
        srlt_word_t immLevel;
        srlt_word_t trigLevel;
        logic trigWritten;
        logic contInit;
        srlt_trig_e trigState;
        srlt_word_t rdData;
        logic rdValid;
    } srlt_top_s;
    typedef struct packed {
        srlt_word_t rise;
        srlt_word_t fall;
        srlt_word_t enab;
        srlt_word_t event_;
        srlt_word_t prevCond;
    } srlt_grp_s;
endpackage

// >>> rtl/srlt_grp_if.sv
// register access carrier between the top and a status group
`timescale 1ns/10ps
interface srlt_grp_if;
    logic [15:0] cond;
    logic [1:0] wrSel;
    logic wrEn;
    logic [15:0] wrData;
    logic evRead;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] enab;
    logic [15:0] event_;
    logic summary;
    modport grp (input cond, input wrSel, input wrEn, input wrData, input evRead,
        output rise, output fall, output enab, output event_, output summary);
    modport top (output cond, output wrSel, output wrEn, output wrData, output evRead,
        input rise, input fall, input enab, input event_, input summary);
endinterface

// >>> rtl/srlt_status_group.sv
// one status group: filters, latched events, enable mask, summary
`timescale 1ns/10ps
`include "srlt_consts.svh"
module srlt_status_group (
    input wire logic mclk,
    input wire logic resetn,
    srlt_grp_if.grp bus
);
    srlt_pkg::srlt_grp_s st;
    srlt_pkg::srlt_grp_s next_st;
    logic [15:0] hits;

    always_comb begin
        next_st = st;
        next_st.prevCond = bus.cond;
        hits = (bus.cond & ~st.prevCond & st.rise)
            | (~bus.cond & st.prevCond & st.fall);
        if (bus.wrEn) begin
            unique case (bus.wrSel)
                2'd0: next_st.rise = bus.wrData;
                2'd1: next_st.fall = bus.wrData;
                default: next_st.enab = bus.wrData;
            endcase
        end
        // clear on read, new hits survive
        next_st.event_ = (bus.evRead ? 16'h0000 : st.event_) | hits;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.rise = st.rise;
    assign bus.fall = st.fall;
    assign bus.enab = st.enab;
    assign bus.event_ = st.event_;
    assign bus.summary = |(st.event_ & st.enab);

    a_rise_sets_event: assert property (@(posedge mclk) disable iff (!resetn)
        (|(bus.cond & ~st.prevCond & st.rise))
        |=> ((st.event_ & $past(bus.cond & ~st.prevCond & st.rise))
            == $past(bus.cond & ~st.prevCond & st.rise)))
        else $error("rising transition not latched");
    a_fall_sets_event: assert property (@(posedge mclk) disable iff (!resetn)
        (|(~bus.cond & st.prevCond & st.fall))
        |=> ((st.event_ & $past(~bus.cond & st.prevCond & st.fall))
            == $past(~bus.cond & st.prevCond & st.fall)))
        else $error("falling transition not latched");
    a_read_clears: assert property (@(posedge mclk) disable iff (!resetn)
        (bus.evRead && hits == 16'h0000) |=> (st.event_ == 16'h0000))
        else $error("event not cleared by read");
    a_event_holds: assert property (@(posedge mclk) disable iff (!resetn)
        !bus.evRead |=> ((st.event_ & $past(st.event_)) == $past(st.event_)))
        else $error("event bit lost without read");
    a_hit_beats_read: assert property (@(posedge mclk) disable iff (!resetn)
        (bus.evRead && hits != 16'h0000) |=> (st.event_ == $past(hits)))
        else $error("event lost on clearing read");
    a_summary_or: assert property (@(posedge mclk) disable iff (!resetn)
        bus.summary == (|(st.event_ & st.enab)))
        else $error("summary mismatch");
endmodule

// >>> rtl/srlt_status_level.sv
// status reporting and double-buffered voltage setpoint
`timescale 1ns/10ps
`include "srlt_consts.svh"
// Overview of operation
// - unpaired immediate write also loads pending level
// - once pending written, immediate writes leave it
// - trigger copies pending level to immediate
// - fixed max/min limits readable per level
// - overvoltage threshold read-only, from panel input
// - abnormal condition live, writes ignored
// - enabled rising transition sets event bit
// - enabled falling transition sets event bit
// - event latches until read, read clears
// - status bit 3 ORs masked abnormal events
// - operation group same, drives status bit 7
// - operation bits: 5 wait, 8 voltage, 10 current
// - abnormal bits 0,1,4,9,10 mapped as listed
// - status byte bits 3..7 mapped as listed
// - trigger clears wait bit; continuous rearms
module srlt_status_level (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    output logic regRdValid,
    input wire logic trigger,
    input wire logic initiate,
    input wire logic [15:0] overvoltageThreshold,
    input wire logic overvoltageTrip,
    input wire logic overcurrentTrip,
    input wire logic overtemperature,
    input wire logic remoteInhibitActive,
    input wire logic outputUnregulated,
    input wire logic constantVoltageMode,
    input wire logic constantCurrentMode,
    input wire logic messageAvailable,
    input wire logic standardEventSummary,
    input wire logic masterSummary,
    output logic [15:0] outputLevel,
    output logic [7:0] summaryStatusByte
);
    srlt_pkg::srlt_top_s st;
    srlt_pkg::srlt_top_s next_st;
    srlt_grp_if abGrp ();
    srlt_grp_if opGrp ();
    logic [15:0] abCond;
    logic [15:0] opCond;
    logic waitingForTrigger;
    logic trigTaken;
    logic [15:0] rdMux;

    // maps a register write to a group's filter/enable select
    function automatic logic [2:0] grp_decode(input logic [4:0] a, input logic [4:0] base);
        grp_decode = 3'b000;
        if (a == base) grp_decode = 3'b100;
        else if (a == base + 5'd1) grp_decode = 3'b101;
        else if (a == base + 5'd3) grp_decode = 3'b110;
    endfunction

    always_comb begin
        abCond = 16'h0000;
        abCond[`SRLT_BIT_OVTRIP] = overvoltageTrip;
        abCond[`SRLT_BIT_OCTRIP] = overcurrentTrip;
        abCond[`SRLT_BIT_OVTEMP] = overtemperature;
        abCond[`SRLT_BIT_INHIBIT] = remoteInhibitActive;
        abCond[`SRLT_BIT_UNREG] = outputUnregulated;
        opCond = 16'h0000;
        opCond[`SRLT_BIT_WAIT] = waitingForTrigger;
        opCond[`SRLT_BIT_CVOLT] = constantVoltageMode;
        opCond[`SRLT_BIT_CCURR] = constantCurrentMode;
    end

    assign waitingForTrigger = (st.trigState == srlt_pkg::SRLT_ARMED);
    assign trigTaken = trigger && waitingForTrigger;

    always_comb begin
        logic [2:0] abSel;
        logic [2:0] opSel;
        abSel = grp_decode(regAddr, `SRLT_ADDR_AB_RISE);
        opSel = grp_decode(regAddr, `SRLT_ADDR_OP_RISE);
        abGrp.cond = abCond;
        abGrp.wrEn = regWrite && abSel[2];
        abGrp.wrSel = abSel[1:0];
        abGrp.wrData = regWrData;
        abGrp.evRead = regRead && (regAddr == `SRLT_ADDR_AB_EVENT);
        opGrp.cond = opCond;
        opGrp.wrEn = regWrite && opSel[2];
        opGrp.wrSel = opSel[1:0];
        opGrp.wrData = regWrData;
        opGrp.evRead = regRead && (regAddr == `SRLT_ADDR_OP_EVENT);
    end

    srlt_status_group uAbnormal (
        .mclk(mclk),
        .resetn(resetn),
        .bus(abGrp)
    );
    srlt_status_group uOperation (
        .mclk(mclk),
        .resetn(resetn),
        .bus(opGrp)
    );

    always_comb begin
        summaryStatusByte = 8'h00;
        summaryStatusByte[`SRLT_STB_ABN] = abGrp.summary;
        summaryStatusByte[`SRLT_STB_MSGAV] = messageAvailable;
        summaryStatusByte[`SRLT_STB_EVSUM] = standardEventSummary;
        summaryStatusByte[`SRLT_STB_MASTER] = masterSummary;
        summaryStatusByte[`SRLT_STB_OPS] = opGrp.summary;
    end

    always_comb begin
        unique case (regAddr)
            `SRLT_ADDR_VOLT_IMM: rdMux = st.immLevel;
            `SRLT_ADDR_VOLT_TRIG: rdMux = st.trigLevel;
            `SRLT_ADDR_VMAX_IMM: rdMux = `SRLT_VMAX_IMM;
            `SRLT_ADDR_VMIN_IMM: rdMux = `SRLT_VMIN_IMM;
            `SRLT_ADDR_VMAX_TRIG: rdMux = `SRLT_VMAX_TRIG;
            `SRLT_ADDR_VMIN_TRIG: rdMux = `SRLT_VMIN_TRIG;
            `SRLT_ADDR_OVTHR: rdMux = overvoltageThreshold;
            `SRLT_ADDR_AB_COND: rdMux = abCond;
            `SRLT_ADDR_AB_RISE: rdMux = abGrp.rise;
            `SRLT_ADDR_AB_FALL: rdMux = abGrp.fall;
            `SRLT_ADDR_AB_EVENT: rdMux = abGrp.event_;
            `SRLT_ADDR_AB_ENAB: rdMux = abGrp.enab;
            `SRLT_ADDR_OP_COND: rdMux = opCond;
            `SRLT_ADDR_OP_RISE: rdMux = opGrp.rise;
            `SRLT_ADDR_OP_FALL: rdMux = opGrp.fall;
            `SRLT_ADDR_OP_EVENT: rdMux = opGrp.event_;
            `SRLT_ADDR_OP_ENAB: rdMux = opGrp.enab;
            `SRLT_ADDR_STB: rdMux = {8'h00, summaryStatusByte};
            `SRLT_ADDR_INIT: rdMux = {15'h0000, st.contInit};
            default: rdMux = 16'h0000;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.rdValid = regRead;
        if (regRead) begin
            next_st.rdData = rdMux;
        end
        if (regWrite) begin
            unique case (regAddr)
                `SRLT_ADDR_VOLT_IMM: begin
                    next_st.immLevel = regWrData;
                    if (!st.trigWritten) begin
                        next_st.trigLevel = regWrData;
                    end
                end
                `SRLT_ADDR_VOLT_TRIG: begin
                    next_st.trigLevel = regWrData;
                    next_st.trigWritten = 1'b1;
                end
                `SRLT_ADDR_INIT: next_st.contInit = regWrData[0];
                default: ;
            endcase
        end
        unique case (st.trigState)
            srlt_pkg::SRLT_IDLE: begin
                if (initiate || st.contInit) begin
                    next_st.trigState = srlt_pkg::SRLT_ARMED;
                end
            end
            srlt_pkg::SRLT_ARMED: begin
                if (trigTaken) begin
                    next_st.immLevel = st.trigLevel;
                    next_st.trigState = srlt_pkg::SRLT_IDLE;
                end
            end
            default: next_st.trigState = srlt_pkg::SRLT_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '{immLevel: 16'h0000, trigLevel: 16'h0000, trigWritten: 1'b0,
                contInit: 1'b0, trigState: srlt_pkg::SRLT_IDLE,
                rdData: 16'h0000, rdValid: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign outputLevel = st.immLevel;
    assign regRdData = st.rdData;
    assign regRdValid = st.rdValid;

    // trigger handshake steps shared by the arm, wait-clear and continuous rearm properties
    sequence s_wait_low;
        !waitingForTrigger;
    endsequence
    sequence s_wait_high;
        waitingForTrigger;
    endsequence
    sequence s_cont_trig;
        trigTaken && st.contInit && !(regWrite && regAddr == `SRLT_ADDR_INIT);
    endsequence

    // setpoint pair
    a_imm_pairs_trig: assert property (@(posedge mclk) disable iff (!resetn)
        (regWrite && regAddr == `SRLT_ADDR_VOLT_IMM && !st.trigWritten && !trigTaken)
        |=> (st.trigLevel == $past(regWrData) && st.immLevel == $past(regWrData)))
        else $error("immediate write did not load pending level");
    a_trig_kept: assert property (@(posedge mclk) disable iff (!resetn)
        (regWrite && regAddr == `SRLT_ADDR_VOLT_IMM && st.trigWritten)
        |=> $stable(st.trigLevel))
        else $error("pending level disturbed");
    a_pend_write: assert property (@(posedge mclk) disable iff (!resetn)
        (regWrite && regAddr == `SRLT_ADDR_VOLT_TRIG)
        |=> (st.trigLevel == $past(regWrData) && st.trigWritten))
        else $error("pending level write lost");
    a_pend_sticky: assert property (@(posedge mclk) disable iff (!resetn)
        st.trigWritten |=> st.trigWritten)
        else $error("pending level marker dropped");
    a_imm_write: assert property (@(posedge mclk) disable iff (!resetn)
        (regWrite && regAddr == `SRLT_ADDR_VOLT_IMM && !trigTaken)
        |=> (outputLevel == $past(regWrData)))
        else $error("immediate write did not reach output");

    // trigger
    a_trig_copies: assert property (@(posedge mclk) disable iff (!resetn)
        trigTaken |=> (outputLevel == $past(st.trigLevel)))
        else $error("trigger did not transfer level");
    a_idle_trig_ignored: assert property (@(posedge mclk) disable iff (!resetn)
        (trigger && !waitingForTrigger && !(regWrite && regAddr == `SRLT_ADDR_VOLT_IMM))
        |=> $stable(outputLevel))
        else $error("trigger taken while not armed");
    a_arm_on_init: assert property (@(posedge mclk) disable iff (!resetn)
        (!waitingForTrigger && (initiate || st.contInit)) |=> s_wait_high)
        else $error("initiate did not arm");
    a_wait_clears: assert property (@(posedge mclk) disable iff (!resetn)
        (trigTaken && !st.contInit && !initiate) |=> s_wait_low ##1
            (!waitingForTrigger || $past(initiate) || $past(st.contInit)))
        else $error("wait bit not cleared");
    a_cont_rearm: assert property (@(posedge mclk) disable iff (!resetn)
        s_cont_trig |=> s_wait_low ##1 s_wait_high)
        else $error("continuous mode did not rearm");
    a_init_write: assert property (@(posedge mclk) disable iff (!resetn)
        (regWrite && regAddr == `SRLT_ADDR_INIT) |=> (st.contInit == $past(regWrData[0])))
        else $error("continuous initiate write lost");

    // register readback
    a_thresh_readback: assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && regAddr == `SRLT_ADDR_OVTHR)
        |=> (regRdValid && regRdData == $past(overvoltageThreshold)))
        else $error("threshold readback wrong");
    a_cond_live: assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && regAddr == `SRLT_ADDR_AB_COND) |=> (regRdData == $past(abCond)))
        else $error("abnormal condition not live");
    a_op_cond_read: assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && regAddr == `SRLT_ADDR_OP_COND) |=> (regRdData == $past(opCond)))
        else $error("operation condition not live");
    a_pend_readback: assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && regAddr == `SRLT_ADDR_VOLT_TRIG) |=> (regRdData == $past(st.trigLevel)))
        else $error("pending level readback wrong");
    a_init_readback: assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && regAddr == `SRLT_ADDR_INIT) |=> (regRdData == {15'h0000, $past(st.contInit)}))
        else $error("continuous initiate readback wrong");
    a_vmax_imm: assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && regAddr == `SRLT_ADDR_VMAX_IMM) |=> (regRdData == `SRLT_VMAX_IMM))
        else $error("immediate maximum wrong");
    a_vmin_imm: assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && regAddr == `SRLT_ADDR_VMIN_IMM) |=> (regRdData == `SRLT_VMIN_IMM))
        else $error("immediate minimum wrong");
    a_vmax_trig: assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && regAddr == `SRLT_ADDR_VMAX_TRIG) |=> (regRdData == `SRLT_VMAX_TRIG))
        else $error("triggered maximum wrong");
    a_vmin_trig: assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && regAddr == `SRLT_ADDR_VMIN_TRIG) |=> (regRdData == `SRLT_VMIN_TRIG))
        else $error("triggered minimum wrong");
    a_stb_read: assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && regAddr == `SRLT_ADDR_STB)
        |=> (regRdData == {8'h00, $past(summaryStatusByte)}))
        else $error("status byte readback wrong");

    // condition and status byte mapping
    a_ab_cond_map: assert property (@(posedge mclk) disable iff (!resetn)
        abCond == {5'h00, outputUnregulated, remoteInhibitActive, 4'h0, overtemperature,
            2'h0, overcurrentTrip, overvoltageTrip})
        else $error("abnormal condition mapping wrong");
    a_op_cond_map: assert property (@(posedge mclk) disable iff (!resetn)
        opCond == {5'h00, constantCurrentMode, 1'b0, constantVoltageMode, 2'h0,
            waitingForTrigger, 5'h00})
        else $error("operation condition mapping wrong");
    a_stb_map: assert property (@(posedge mclk) disable iff (!resetn)
        summaryStatusByte[7:3] == {opGrp.summary, masterSummary, standardEventSummary,
            messageAvailable, abGrp.summary})
        else $error("status byte mapping wrong");
    a_stb_low_zero: assert property (@(posedge mclk) disable iff (!resetn)
        summaryStatusByte[2:0] == 3'h0)
        else $error("unused status bits set");
    a_ab_summary: assert property (@(posedge mclk) disable iff (!resetn)
        summaryStatusByte[3] == (|(abGrp.event_ & abGrp.enab)))
        else $error("abnormal summary wrong");
    a_op_summary: assert property (@(posedge mclk) disable iff (!resetn)
        summaryStatusByte[7] == (|(opGrp.event_ & opGrp.enab)))
        else $error("operation summary wrong");
endmodule

// >>> sim/srlt_host_model.sv
// remote host model issuing register writes and reads
`timescale 1ns/10ps
module srlt_host_model (
    input wire logic mclk,
    output logic regWrite,
    output logic regRead,
    output logic [4:0] regAddr,
    output logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic regRdValid
);
    initial begin
        regWrite = 1'h0;
        regRead = 1'h0;
        regAddr = 5'h00;
        regWrData = 16'h0000;
    end
    // idle bus shows the inverse of the last value, not a stale copy
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge mclk);
        #1;
        regAddr = a;
        regWrData = v;
        regWrite = 1'h1;
        @(posedge mclk);
        #1;
        regWrite = 1'h0;
        regAddr = ~a;
        regWrData = ~v;
    endtask
    // bounded wait for read data; none leaves unknowns behind
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        v = 16'hXXXX;
        @(posedge mclk);
        #1;
        regAddr = a;
        regRead = 1'h1;
        @(posedge mclk);
        #1;
        regRead = 1'h0;
        regAddr = ~a;
        for (int i = 0; i < 4; i++) begin
            if (regRdValid === 1'h1) begin
                v = regRdData;
                break;
            end
            @(posedge mclk);
            #1;
        end
    endtask
endmodule

// >>> sim/srlt_status_level_tb.sv
// self-checking bench for the status reporting and level trigger block
`timescale 1ns/10ps
`include "srlt_consts.svh"
`define CK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module srlt_status_level_tb;
    logic mclk, resetn, regWrite, regRead, regRdValid, trigger, initiate;
    logic [4:0] regAddr, abM;
    logic [15:0] regWrData, regRdData, outputLevel, overvoltageThreshold;
    logic [7:0] summaryStatusByte;
    logic [1:0] opM;
    logic [2:0] sb;
    int n_mismatch = 0;
    int tests_run = 0;

    srlt_host_model u_host (.mclk, .regWrite, .regRead, .regAddr, .regWrData,
        .regRdData, .regRdValid);
    srlt_status_level u_dut (.mclk, .resetn, .regWrite, .regRead, .regAddr,
        .regWrData, .regRdData, .regRdValid, .trigger, .initiate,
        .overvoltageThreshold, .overvoltageTrip(abM[0]), .overcurrentTrip(abM[1]),
        .overtemperature(abM[2]), .remoteInhibitActive(abM[3]),
        .outputUnregulated(abM[4]), .constantVoltageMode(opM[0]),
        .constantCurrentMode(opM[1]), .messageAvailable(sb[0]),
        .standardEventSummary(sb[1]), .masterSummary(sb[2]), .outputLevel,
        .summaryStatusByte);

    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end

    function automatic logic [15:0] abExp(input logic [4:0] m);
        return {5'h00, m[4], m[3], 4'h0, m[2], 2'h0, m[1], m[0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // k=1 trigger, k=0 initiate
    task automatic pulse(input int k);
        if (k == 1) trigger = 1'h1;
        else initiate = 1'h1;
        tick(1);
        trigger = 1'h0;
        initiate = 1'h0;
    endtask

    task automatic results();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        results();
    end

    initial begin
        logic [15:0] d, v1, v2, v3;
        logic [15:0] lim [4];
        lim = '{`SRLT_VMAX_IMM, `SRLT_VMIN_IMM, `SRLT_VMAX_TRIG, `SRLT_VMIN_TRIG};
        void'($urandom(96));
        {trigger, initiate, abM, opM, sb} = '0;
        overvoltageThreshold = 16'($urandom);
        resetn = 1'h0;
        tick(2);
        resetn = 1'h1;
        u_host.rd(`SRLT_ADDR_STB, d);
        `CK(d, 16'h0000)
        for (int i = 0; i < 4; i++) begin
            u_host.rd(5'(`SRLT_ADDR_VMAX_IMM + i), d);
            `CK(d, lim[i])
        end
        u_host.wr(`SRLT_ADDR_OVTHR, ~overvoltageThreshold);
        u_host.rd(`SRLT_ADDR_OVTHR, d);
        `CK(d, overvoltageThreshold)
        v1 = 16'($urandom);
        v2 = 16'($urandom);
        v3 = ~v2;
        u_host.wr(`SRLT_ADDR_VOLT_IMM, v1);
        u_host.rd(`SRLT_ADDR_VOLT_TRIG, d);
        `CK(d, v1)
        `CK(outputLevel, v1)
        u_host.wr(`SRLT_ADDR_VOLT_TRIG, v2);
        u_host.wr(`SRLT_ADDR_VOLT_IMM, v3);
        u_host.rd(`SRLT_ADDR_VOLT_TRIG, d);
        `CK(d, v2)
        `CK(outputLevel, v3)
        // trigger while idle is ignored
        pulse(1);
        tick(1);
        `CK(outputLevel, v3)
        pulse(0);
        u_host.rd(`SRLT_ADDR_OP_COND, d);
        `CK(d, 16'h0020)
        pulse(1);
        tick(1);
        `CK(outputLevel, v2)
        u_host.rd(`SRLT_ADDR_OP_COND, d);
        `CK(d, 16'h0000)
        u_host.wr(`SRLT_ADDR_INIT, 16'h0001);
        pulse(0);
        pulse(1);
        tick(3);
        u_host.rd(`SRLT_ADDR_OP_COND, d);
        `CK(d, 16'h0020)
        repeat (8) begin
            abM = 5'($urandom);
            u_host.wr(`SRLT_ADDR_AB_COND, 16'($urandom));
            u_host.rd(`SRLT_ADDR_AB_COND, d);
            `CK(d, abExp(abM))
        end
        abM = 5'h00;
        tick(2);
        u_host.wr(`SRLT_ADDR_AB_RISE, 16'h0010);
        u_host.wr(`SRLT_ADDR_AB_FALL, 16'h0200);
        u_host.wr(`SRLT_ADDR_AB_ENAB, 16'h0210);
        abM[2] = 1'h1;
        tick(3);
        `CK(summaryStatusByte[3], 1'h1)
        u_host.rd(`SRLT_ADDR_AB_EVENT, d);
        `CK(d, 16'h0010)
        u_host.rd(`SRLT_ADDR_AB_EVENT, d);
        `CK(d, 16'h0000)
        `CK(summaryStatusByte[3], 1'h0)
        abM[3] = 1'h1;
        tick(3);
        abM[3] = 1'h0;
        tick(3);
        u_host.rd(`SRLT_ADDR_AB_EVENT, d);
        `CK(d, 16'h0200)
        u_host.wr(`SRLT_ADDR_AB_ENAB, 16'h0000);
        abM[2] = 1'h0;
        tick(2);
        // rising edge lands on the clearing read
        fork
            u_host.rd(`SRLT_ADDR_AB_EVENT, d);
            begin
                @(posedge mclk);
                #1;
                abM[2] = 1'h1;
            end
        join
        `CK(d, 16'h0000)
        tick(2);
        `CK(summaryStatusByte[3], 1'h0)
        u_host.rd(`SRLT_ADDR_AB_EVENT, d);
        `CK(d, 16'h0010)
        u_host.wr(`SRLT_ADDR_OP_RISE, 16'h0100);
        u_host.wr(`SRLT_ADDR_OP_FALL, 16'h0020);
        u_host.wr(`SRLT_ADDR_OP_ENAB, 16'h0120);
        opM = 2'h3;
        tick(3);
        `CK(summaryStatusByte[7], 1'h1)
        u_host.rd(`SRLT_ADDR_OP_COND, d);
        `CK(d, 16'h0520)
        u_host.rd(`SRLT_ADDR_OP_EVENT, d);
        `CK(d, 16'h0100)
        pulse(1);
        tick(3);
        u_host.rd(`SRLT_ADDR_OP_EVENT, d);
        `CK(d, 16'h0020)
        for (int i = 0; i < 8; i++) begin
            sb = 3'(i);
            u_host.rd(`SRLT_ADDR_STB, d);
            `CK(d, {8'h00, 1'h0, sb, 4'h0})
        end
        results();
    end
endmodule
